// File: rtl/cdm_pkg.sv
// Shared constants and types for the clock deskew lock monitor
package cdm_pkg;
  localparam int TAP_W           = 4;
  localparam int LINE_DEPTH      = 16;
  localparam int CNT_W           = 16;
  localparam int CLK_MHZ         = 125;
  // Synthesizer stopped flag delay, in microseconds, and in cycles
  localparam int SYNTH_STOP_US   = 100;
  localparam int SYNTH_STOP_CYC  = SYNTH_STOP_US * CLK_MHZ;
  // Reference counted as stopped after this many cycles with no edge
  localparam logic [CNT_W-1:0] STOP_DETECT = 16'h0040;
  // Tolerated period change after lock, in cycles
  localparam logic [CNT_W-1:0] PERIOD_TOL  = 16'h0002;
  localparam logic [2:0] LOCK_MATCHES      = 3'h4;
  localparam int REFILL_DEFAULT  = 2;
  localparam int FB_SYS_TAPS     = 2;
  // Start-up phase code meaning no wait for lock
  localparam logic [2:0] PHASE_NO_WAIT     = 3'h7;
  localparam logic [CNT_W-1:0] CNT_MAX     = 16'hffff;

  typedef enum logic [1:0] {
    CDM_ACQUIRE = 2'b00,
    CDM_LOCKED  = 2'b01,
    CDM_LOST    = 2'b10
  } cdm_lock_e;
endpackage

// File: rtl/cdm_tap_if.sv
// Tap-selected delay line connection
`timescale 1ns/1ps
`default_nettype none
interface cdm_tap_if;
  logic                     din;
  logic [cdm_pkg::TAP_W-1:0] tap;
  logic                     dout;
  modport line (input din, input tap, output dout);
  modport user (output din, output tap, input dout);
endinterface // cdm_tap_if
`default_nettype wire

// File: rtl/cdm_delay_line.sv
// Shift-register delay line with registered tap output
`timescale 1ns/1ps
`default_nettype none
module cdm_delay_line #(
  parameter int DEPTH = cdm_pkg::LINE_DEPTH
) (
  input  wire logic   ref_clk,
  input  wire logic   rst,
  cdm_tap_if.line     lnk
);
  typedef struct packed {
    logic [DEPTH-1:0] sh;
    logic             dout;
  } cdm_line_s;

  cdm_line_s q;
  cdm_line_s next_q;

  always_comb begin
    next_q      = q;
    next_q.sh   = {q.sh[DEPTH-2:0], lnk.din};
    next_q.dout = q.sh[lnk.tap];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign lnk.dout = q.dout;
endmodule // cdm_delay_line
`default_nettype wire

// File: rtl/cdm_deskew_monitor.sv
// Deskew loop, lock tracking and stop status of the clock manager
// Function
// [RQ1] Step tap until feedback edge meets reference
// [RQ2] Drop lock on period drift; reset needed
// [RQ3] Controller resets after large period change; here lock stays in CDM_LOST until a reset
// [RQ4] Stopped reference halts synth; flag set
// [RQ5] Synth stopped flag after 100 us, sticky
// [RQ6] Pause under 100 ms, steady level
// [RQ7] Lock stays high through permitted pause
// [RQ8] Output keeps running while line drains
// [RQ9] Flag input stopped once output stops
// [RQ10] Suppress output while line refills
// [RQ11] Clear input stopped when output resumes
// [RQ12] Input stopped forced low while unlocked
// [RQ13] Users ignore outputs before lock
// [RQ14] Held in reset during configuration
// [RQ15] Clocks stable when locking begins
// [RQ16] Start-up waits in chosen phase for lock
// [RQ17] Lock-wait phase needs hold option enabled
// [RQ18] Lock-wait phase after tristate release
// [RQ19] System-synchronous adds feedback delay taps
// [RQ20] Source-synchronous sets feedback delay zero
// [RQ21] No feedback delay in bypass cases
// [RQ22] Hold-for-lock option defaults false
// [RQ23] Reset clears flags, restarts at tap zero
`timescale 1ns/1ps
`default_nettype none
module cdm_deskew_monitor #(
  parameter int SYNTH_STOP_CYCLES   = cdm_pkg::SYNTH_STOP_CYC,
  parameter int REFILL_CLOCKS       = cdm_pkg::REFILL_DEFAULT,
  parameter int FB_DELAY_TAPS       = cdm_pkg::FB_SYS_TAPS,
  parameter bit HOLD_STARTUP_FOR_LOCK = 1'b0
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      reference_clock_in,
  input  wire logic                      feedback_clock_in,
  input  wire logic                      in_configuration,
  input  wire logic                      synth_in_use,
  input  wire logic                      source_sync_mode,
  input  wire logic                      cascaded_downstream,
  input  wire logic                      external_feedback,
  input  wire logic                      ref_not_dedicated,
  input  wire logic [2:0]                startup_phase,
  input  wire logic [2:0]                lock_wait_phase,
  output var  logic                      aligned_clock_out,
  output var  logic                      synth_clock_out,
  output var  logic                      synth_clock_inverted_out,
  output var  logic                      locked,
  output var  logic                      input_stopped,
  output var  logic                      synth_stopped,
  output var  logic                      startup_hold,
  output var  logic [cdm_pkg::TAP_W-1:0] delay_step
);
  localparam int W = cdm_pkg::CNT_W;
  localparam logic [W-1:0] SYNTH_LIMIT = W'(SYNTH_STOP_CYCLES);
  localparam logic [3:0]   REFILL_N    = 4'(REFILL_CLOCKS);
  localparam logic [cdm_pkg::TAP_W-1:0] FB_TAPS = cdm_pkg::TAP_W'(FB_DELAY_TAPS);

  typedef struct packed {
    logic [2:0]                rsync;
    logic                      rlev;
    logic                      rprev;
    logic [2:0]                fsync;
    logic                      flev;
    logic                      fdprev;
    cdm_pkg::cdm_lock_e        st;
    logic [cdm_pkg::TAP_W-1:0] tap;
    logic [2:0]                match;
    logic                      locked;
    logic [W-1:0]              pcnt;
    logic [W-1:0]              lock_per;
    logic                      ref_stopped;
    logic [3:0]                refill;
    logic [W-1:0]              ocnt;
    logic                      input_stopped;
    logic                      synth_halted;
    logic [W-1:0]              synth_cnt;
    logic                      synth_stopped;
    logic [cdm_pkg::TAP_W-1:0] fb_taps;
    logic                      aligned;
    logic                      synth;
    logic                      synth_n;
    logic                      startup_hold;
  } cdm_state_s;

  cdm_state_s q;
  cdm_state_s next_q;
  logic       rst_all;
  logic       r_rise;
  logic       fb_rise;
  logic       out_on;
  logic [W-1:0] pdiff;

  cdm_tap_if main_line ();
  cdm_tap_if fb_line ();

  function automatic logic [W-1:0] cdm_sat_inc(input logic [W-1:0] v);
    cdm_sat_inc = (v == cdm_pkg::CNT_MAX) ? v : v + 1'b1;
  endfunction

  // Configuration holds the whole block in reset
  assign rst_all = rst | in_configuration; // see [RQ14]

  assign main_line.din = q.rlev;
  assign main_line.tap = q.tap;
  assign fb_line.din   = q.flev;
  assign fb_line.tap   = q.fb_taps;

  cdm_delay_line #(.DEPTH(cdm_pkg::LINE_DEPTH)) u_main_line (
    .ref_clk (ref_clk),
    .rst     (rst_all),
    .lnk     (main_line)
  );

  cdm_delay_line #(.DEPTH(cdm_pkg::LINE_DEPTH)) u_fb_line (
    .ref_clk (ref_clk),
    .rst     (rst_all),
    .lnk     (fb_line)
  );

  assign r_rise  = q.rlev & ~q.rprev;
  assign fb_rise = fb_line.dout & ~q.fdprev;
  assign pdiff   = (q.pcnt > q.lock_per) ? q.pcnt - q.lock_per
                                         : q.lock_per - q.pcnt;
  // Delayed reference, blanked while the line refills
  assign out_on  = main_line.dout & (q.refill == 4'h0); // see [RQ10]

  always_comb begin
    next_q = q;
    // Pins pass three flops; a level counts when stages two and three agree
    next_q.rsync = {q.rsync[1:0], reference_clock_in};
    next_q.fsync = {q.fsync[1:0], feedback_clock_in};
    if (q.rsync[1] == q.rsync[2]) begin
      next_q.rlev = q.rsync[2];
    end
    if (q.fsync[1] == q.fsync[2]) begin
      next_q.flev = q.fsync[2];
    end
    next_q.rprev  = q.rlev;
    next_q.fdprev = fb_line.dout;

    // Feedback delay element setting
    if (source_sync_mode || cascaded_downstream || external_feedback ||
        ref_not_dedicated) begin
      next_q.fb_taps = '0; // see [RQ20] see [RQ21]
    end else begin
      next_q.fb_taps = FB_TAPS; // see [RQ19]
    end

    // Period measurement and reference stop detection
    if (r_rise) begin
      next_q.pcnt        = '0;
      next_q.ref_stopped = 1'b0;
      if (q.ref_stopped) begin
        next_q.refill = REFILL_N; // see [RQ10]
      end else if (q.refill != 4'h0) begin
        next_q.refill = q.refill - 4'h1;
      end
    end else begin
      next_q.pcnt = cdm_sat_inc(q.pcnt);
      if (q.pcnt >= cdm_pkg::STOP_DETECT) begin
        next_q.ref_stopped = 1'b1;
      end
    end

    case (q.st)
      cdm_pkg::CDM_ACQUIRE: begin
        if (r_rise) begin
          if (fb_rise) begin
            next_q.match = q.match + 3'h1;
            if (q.match + 3'h1 == cdm_pkg::LOCK_MATCHES) begin
              next_q.st       = cdm_pkg::CDM_LOCKED; // see [RQ1]
              next_q.locked   = 1'b1;
              next_q.lock_per = q.pcnt;
            end
          end else begin
            // Add one step of delay and try again
            next_q.match = '0;
            next_q.tap   = q.tap + 1'b1; // see [RQ1]
          end
        end
      end
      cdm_pkg::CDM_LOCKED: begin
        // A pause-ending edge spans the pause, so skip it; see [RQ7]
        if (r_rise && !q.ref_stopped && pdiff > cdm_pkg::PERIOD_TOL) begin
          next_q.st     = cdm_pkg::CDM_LOST; // see [RQ2]
          next_q.locked = 1'b0;
        end
      end
      cdm_pkg::CDM_LOST: begin
        // Only a reset leaves this state
        next_q.locked = 1'b0; // see [RQ2]
      end
      default: begin
        next_q.st     = cdm_pkg::CDM_ACQUIRE;
        next_q.locked = 1'b0;
      end
    endcase

    // Output stop tracking; the line drains on its own after a halt
    if (out_on && !q.aligned) begin
      next_q.ocnt          = '0;
      next_q.input_stopped = 1'b0; // see [RQ11]
    end else begin
      next_q.ocnt = cdm_sat_inc(q.ocnt); // see [RQ8]
      if (q.ocnt >= cdm_pkg::STOP_DETECT) begin
        next_q.input_stopped = 1'b1; // see [RQ9]
      end
    end
    if (!next_q.locked) begin
      next_q.input_stopped = 1'b0; // see [RQ12]
    end

    // Synthesizer halts for good when its reference goes away
    if (q.ref_stopped && synth_in_use) begin
      next_q.synth_halted = 1'b1; // see [RQ4]
    end
    if (q.synth_halted && !q.synth_stopped) begin
      next_q.synth_cnt = q.synth_cnt + 1'b1;
      if (q.synth_cnt + 1'b1 == SYNTH_LIMIT) begin
        next_q.synth_stopped = 1'b1; // see [RQ5]
      end
    end

    next_q.aligned = out_on;
    next_q.synth   = out_on & ~next_q.synth_halted;
    next_q.synth_n = ~out_on & ~next_q.synth_halted;
    next_q.startup_hold = HOLD_STARTUP_FOR_LOCK &&
                          (lock_wait_phase != cdm_pkg::PHASE_NO_WAIT) &&
                          (startup_phase == lock_wait_phase) &&
                          !q.locked; // see [RQ16] see [RQ22]
  end

  // Reset clears every flag and puts the selector back to tap zero
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      q <= '0; // see [RQ23]
    end else begin
      q <= next_q;
    end
  end

  assign aligned_clock_out        = q.aligned;
  assign synth_clock_out          = q.synth;
  assign synth_clock_inverted_out = q.synth_n;
  assign locked                   = q.locked;
  assign input_stopped            = q.input_stopped;
  assign synth_stopped            = q.synth_stopped;
  assign startup_hold             = q.startup_hold;
  assign delay_step               = q.tap;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst_all);

  chk_lock_on_match: assert property ( // see [RQ1]
    $rose(q.locked) |-> $past(r_rise) && $past(fb_rise))
    else $error("lock rose without matching edges");
  chk_tap_step_up: assert property ( // see [RQ1]
    (q.st == cdm_pkg::CDM_ACQUIRE && r_rise && !fb_rise) |=>
      q.tap == $past(q.tap) + 1'b1)
    else $error("tap did not step on mismatch");
  chk_lost_stays: assert property ( // see [RQ2]
    (q.st == cdm_pkg::CDM_LOST) |=> !q.locked ##1 !q.locked)
    else $error("lock returned without reset");
  chk_synth_delay: assert property ( // see [RQ5]
    $rose(q.synth_stopped) |-> q.synth_cnt == SYNTH_LIMIT && q.synth_halted)
    else $error("synth stopped flag at wrong time");
  chk_synth_sticky: assert property ( // see [RQ4]
    q.synth_halted |=> !synth_clock_out && !synth_clock_inverted_out)
    else $error("synth clock ran after halt");
  chk_pause_lock: assert property ( // see [RQ7]
    (q.locked && q.ref_stopped) |=> q.locked)
    else $error("lock dropped during pause");
  chk_unlock_clear: assert property ( // see [RQ12]
    !locked |-> !input_stopped)
    else $error("input stopped high while unlocked");
  chk_refill_blank: assert property ( // see [RQ10]
    (q.refill != 4'h0) |=> !aligned_clock_out)
    else $error("output ran during refill");
  chk_fb_zero: assert property ( // see [RQ20]
    (source_sync_mode || external_feedback) |=> q.fb_taps == '0)
    else $error("feedback delay not zero");
  chk_resume_clear: assert property ( // see [RQ11]
    $rose(aligned_clock_out) |=> !input_stopped)
    else $error("input stopped not cleared on resume");
endmodule // cdm_deskew_monitor
`default_nettype wire

// File: tb/cdm_fb_return.sv
// Clock network model that returns the aligned clock as feedback
`timescale 1ns/1ps
`default_nettype none
module cdm_fb_return #(
  parameter int DLY = 3
) (
  input  wire logic ref_clk,
  input  wire logic clk_in,
  output var  logic clk_out
);
  logic [DLY-1:0] pipe = '0;
  // Network never stops returning, so feedback is present at lock start
  always @(posedge ref_clk) begin
    pipe <= {pipe[DLY-2:0], clk_in};
  end
  assign clk_out = pipe[DLY-1];
endmodule // cdm_fb_return
`default_nettype wire

// File: tb/cdm_deskew_monitor_tb.sv
// Self-checking bench for the clock deskew lock monitor
`timescale 1ns/1ps
`default_nettype none
module cdm_deskew_monitor_tb;
  localparam int STOP = 50;
  // Lock tap, system-sync: 16-cycle period less 12 loop, 2 feedback cycles
  localparam logic [3:0] TAP0 = 4'h2;
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] off;
    logic [2:0] sph;
    logic [2:0] lwp;
    logic       hold;
  } cdm_row_s;
  // Mode bits: source-sync, cascaded, external feedback, not dedicated
  cdm_row_s rows [5] = '{
    '{4'h0, 4'h0, 3'h3, 3'h3, 1'b1},
    '{4'h8, 4'h2, 3'h3, 3'h7, 1'b0},
    '{4'h4, 4'h2, 3'h2, 3'h3, 1'b0},
    '{4'h2, 4'h2, 3'h5, 3'h5, 1'b1},
    '{4'h1, 4'h2, 3'h7, 3'h7, 1'b0}};
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       ref_in  = 1'b0;
  logic       run     = 1'b1;
  logic       cfg     = 1'b0;
  logic       use_syn = 1'b0;
  logic [3:0] mode    = 4'h0;
  logic [2:0] sph     = 3'h0;
  logic [2:0] lwp     = 3'h7;
  logic       fb, aln, syn, syn_n, locked, in_stop, syn_stop, hold;
  logic [3:0] step;
  int         half = 8, cnt = 0, errors = 0, compares = 0, n = 0;

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Reference pauses hold their level, as a permitted stop must
  always @(posedge ref_clk) begin
    if (run) begin
      if (cnt >= half - 1) begin
        cnt    <= 0;
        ref_in <= !ref_in;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  cdm_fb_return #(.DLY(3)) u_net (
    .ref_clk(ref_clk), .clk_in(aln), .clk_out(fb));

  // Hold option on so lock-wait phases take effect
  cdm_deskew_monitor #(
    .SYNTH_STOP_CYCLES(STOP),
    .HOLD_STARTUP_FOR_LOCK(1'b1)
  ) u_dut (
    .ref_clk(ref_clk), .rst(rst), .reference_clock_in(ref_in),
    .feedback_clock_in(fb), .in_configuration(cfg),
    .synth_in_use(use_syn), .source_sync_mode(mode[3]),
    .cascaded_downstream(mode[2]), .external_feedback(mode[1]),
    .ref_not_dedicated(mode[0]), .startup_phase(sph),
    .lock_wait_phase(lwp), .aligned_clock_out(aln),
    .synth_clock_out(syn), .synth_clock_inverted_out(syn_n),
    .locked(locked), .input_stopped(in_stop), .synth_stopped(syn_stop),
    .startup_hold(hold), .delay_step(step));

  function automatic logic val(input int w);
    case (w)
      0: return locked;
      1: return in_stop;
      2: return syn_stop;
      3: return !in_stop;
      default: return !locked;
    endcase
  endfunction

  task automatic wait_for(input int w, input int lim);
    n = 0;
    while (val(w) !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic chk(input logic [3:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic chk_rng(input int lo, hi, input string m);
    compares++;
    if (n < lo || n > hi) begin
      errors++;
      $display("CHECK FAILED %0t %s n=%0d", $time, m, n);
    end
  endtask

  task automatic do_rst(input int cyc);
    rst <= 1'b1;
    repeat (cyc) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (11) @(posedge ref_clk);
    chk({locked, in_stop, syn_stop, hold}, 4'h0, "in reset");
    chk(step, 4'h0, "tap in reset");
    @(posedge ref_clk);
    rst <= 1'b0;
    // Lock, stop flag and hold may not move in the first two edges after release
    repeat (2) begin
      @(posedge ref_clk);
      chk({locked, in_stop, hold}, 4'h0, "after release");
    end
    foreach (rows[i]) begin
      mode <= rows[i].mode;
      sph  <= rows[i].sph;
      lwp  <= rows[i].lwp;
      do_rst(20);
      repeat (40) @(posedge ref_clk);
      chk(in_stop, 1'b0, "stop flag while unlocked");
      chk(hold, rows[i].hold, "start-up hold");
      wait_for(0, 2000);
      chk(locked, 1'b1, "lock reached");
      chk(step, TAP0 + rows[i].off, "locked tap");
      chk({syn, syn_n}, {aln, !aln}, "synth follows aligned");
      repeat (2) @(posedge ref_clk);
      chk(hold, 1'b0, "hold released at lock");
    end
    run <= 1'b0;
    wait_for(1, 300);
    chk_rng(40, 120, "stop flag after output stops");
    chk({locked, syn_stop}, 4'h2, "lock held in pause");
    run <= 1'b1;
    wait_for(3, 120);
    chk_rng(20, 100, "stop flag clears on resume");
    repeat (100) @(posedge ref_clk);
    chk(locked, 1'b1, "lock after restart");
    use_syn <= 1'b1;
    run     <= 1'b0;
    wait_for(2, 400);
    chk_rng(STOP + 40, STOP + 90, "synth stopped delay");
    chk({syn, syn_n}, 4'h0, "synth outputs halted");
    run <= 1'b1;
    repeat (150) @(posedge ref_clk);
    chk({syn_stop, syn, syn_n}, 4'h4, "synth halt sticky");
    use_syn <= 1'b0;
    rst     <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk({locked, in_stop, syn_stop}, 4'h0, "reset clears");
    chk(step, 4'h0, "reset restarts tap");
    rst <= 1'b0;
    wait_for(0, 2000);
    half <= 10;
    wait_for(4, 200);
    chk_rng(1, 199, "lock lost on period drift");
    chk(in_stop, 1'b0, "stop flag low when unlocked");
    half <= 8;
    repeat (200) @(posedge ref_clk);
    chk(locked, 1'b0, "loss held until reset");
    do_rst(20);
    wait_for(0, 2000);
    cfg <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(locked, 1'b0, "configuration resets lock");
    chk(step, 4'h0, "configuration resets tap");
    cfg <= 1'b0;
    wait_for(0, 2000);
    chk(locked, 1'b1, "lock after configuration");
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    end_sim();
  end
endmodule // cdm_deskew_monitor_tb
`default_nettype wire
